/* design/scpns_pkg.sv */
package scpns_pkg;

  localparam int          INSTR_BITS      = 16;
  localparam int          ADDR_W          = 13;
  localparam int          REG_COUNT       = 562;
  localparam int          NVM_BYTES       = 512;
  localparam int          NVM_IDX_W       = 9;
  localparam logic [12:0] CFG_OFS         = 13'h0000;
  localparam logic [12:0] COMMIT_OFS      = 13'h0232;
  localparam logic [12:0] XFER_ACTIVE_OFS = 13'h0B00;
  localparam logic [12:0] XFER_ERROR_OFS  = 13'h0B01;
  localparam logic [12:0] WR_ENABLE_OFS   = 13'h0B02;
  localparam logic [12:0] COPY_REQ_OFS    = 13'h0B03;
  localparam logic [12:0] LAST_REG        = 13'h0232;
  localparam logic [7:0]  CFG_RESET       = 8'h18;
  localparam int          CFG_SDO_EN      = 0;
  localparam int          CFG_LSB_LO      = 1;
  localparam int          CFG_LSB_HI      = 6;
  localparam int          CFG_UNIDIR      = 7;
  localparam int          INSTR_RW        = 15;
  localparam logic [1:0]  LEN_STREAM      = 2'h3;
  localparam logic [3:0]  INSTR_LAST_BIT  = 4'hF;
  localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA  = 2'b01,
    ST_DONE  = 2'b10
  } scpns_state_t;

endpackage

/* design/scpns_store_engine.sv */
`timescale 1ns/1ns
module scpns_store_engine
  import scpns_pkg::*;
(
  input  wire logic                            ref_clk,
  input  wire logic                            reset,
  input  wire logic                            start,
  input  wire logic                            write_enable,
  input  wire logic [7:0]                      src_data,
  output logic      [scpns_pkg::NVM_IDX_W-1:0] src_index,
  output logic                                 busy,
  output logic                                 error,
  output logic                                 done
);
  import scpns_pkg::*;

  logic [7:0]           nvm_mem [NVM_BYTES];
  logic [NVM_IDX_W-1:0] idx_r;
  logic                 busy_r;
  logic                 err_r;
  logic                 done_r;
  wire                  last_w = (idx_r == NVM_IDX_W'(NVM_BYTES - 1));

  // The store is only ever filled from the register copy, never from the port.
  // copy-only fill
  always_ff @(posedge ref_clk)
    if (busy_r && write_enable)
      nvm_mem[idx_r] <= src_data;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      idx_r  <= '0;
      busy_r <= 1'b0;
      err_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= busy_r && last_w;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        idx_r  <= '0;
        err_r  <= !write_enable;
      end
      else if (busy_r)
      begin
        idx_r <= idx_r + 1'b1;
        // A write enable dropped mid-copy leaves a partial image, so it is an error.
        // error report
        if (!write_enable)
          err_r <= 1'b1;
        if (last_w)
          busy_r <= 1'b0;
      end
    end
  end

  assign src_index = idx_r;
  assign busy      = busy_r;
  assign error     = err_r;
  assign done      = done_r;

  property p_store_start;
    @(posedge ref_clk) disable iff (reset) (start && !busy_r) |=> busy_r && idx_r == '0;
  endproperty
  a_store_start: assert property (p_store_start) else $error("store did not start");

  property p_store_error;
    @(posedge ref_clk) disable iff (reset) (start && !busy_r && !write_enable) |=> err_r;
  endproperty
  a_store_error: assert property (p_store_error) else $error("missing store error");

  c_store_done: cover property (@(posedge ref_clk) disable iff (reset) done_r && !err_r);

endmodule // scpns_store_engine

/* design/scpns_serial_port.sv */
`timescale 1ns/1ns
module scpns_serial_port
  import scpns_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdio_in,
  input  wire logic status_pin_sel,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      serial_readback_out,
  output logic      serial_readback_oe,
  output logic      status_pin,
  output logic      addr_nack
);
  import scpns_pkg::*;

  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic sdi_s1, sdi_s2;
  logic sel_s1, sel_s2;

  always_ff @(posedge ref_clk)
  begin
    sclk_s1 <= sclk;
    sclk_s2 <= sclk_s1;
    sclk_s3 <= sclk_s2;
    cs_s1   <= cs_n;
    cs_s2   <= cs_s1;
    cs_s3   <= cs_s2;
    sdi_s1  <= sdio_in;
    sdi_s2  <= sdi_s1;
    sel_s1  <= status_pin_sel;
    sel_s2  <= sel_s1;
  end

  scpns_state_t         state_r;
  logic [3:0]           cnt_r;
  logic [15:0]          instr_r;
  logic [7:0]           rx_r;
  logic [7:0]           tx_r;
  logic [ADDR_W-1:0]    addr_r;
  logic [1:0]           left_r;
  logic                 rd_r;
  logic                 stream_r;
  logic [7:0]           cfg_r;
  logic                 commit_r;
  logic                 wr_en_r;
  logic                 copy_req_r;
  logic                 sdo_bit_r;
  logic                 sdio_out_r, sdio_oe_r, ro_out_r, ro_oe_r, status_r, nack_r;
  logic [7:0]           buf_mem [REG_COUNT];
  logic [7:0]           act_mem [REG_COUNT];
  logic                 busy, store_err, store_done;
  logic [NVM_IDX_W-1:0] src_index;

  wire sclk_rise = sclk_s2 && !sclk_s3 && !cs_s2;
  wire cs_rise   = cs_s2 && !cs_s3;
  wire lsb_first = cfg_r[CFG_LSB_LO] | cfg_r[CFG_LSB_HI];
  wire unidir    = cfg_r[CFG_UNIDIR] & cfg_r[CFG_SDO_EN];

  wire [15:0] instr_nxt = lsb_first ? {sdi_s2, instr_r[15:1]} : {instr_r[14:0], sdi_s2};
  wire [7:0]  rx_nxt    = lsb_first ? {sdi_s2, rx_r[7:1]} : {rx_r[6:0], sdi_s2};

  wire instr_end = sclk_rise && state_r == ST_INSTR && cnt_r == INSTR_LAST_BIT;
  wire byte_end  = sclk_rise && state_r == ST_DATA && cnt_r[2:0] == BYTE_LAST_BIT;
  wire at_last   = stream_r && addr_r == LAST_REG;

  wire [ADDR_W-1:0] addr_step = lsb_first ? addr_r + 1'b1 :
                                (addr_r == '0) ? LAST_REG : addr_r - 1'b1;
  wire [ADDR_W-1:0] rd_addr   = instr_end ? instr_nxt[ADDR_W-1:0] : addr_step;

  wire wr_stb = byte_end && !rd_r && !busy;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire in_map = rd_addr < ADDR_W'(REG_COUNT);
  wire [7:0] map_byte = in_map ? act_mem[rd_addr[9:0]] : 8'h00;
  wire [7:0] rd_byte =
    hit(rd_addr, XFER_ACTIVE_OFS) ? {7'h00, busy} :
    busy                          ? 8'h00 :
    hit(rd_addr, CFG_OFS)         ? cfg_r :
    hit(rd_addr, COMMIT_OFS)      ? {7'h00, commit_r} :
    hit(rd_addr, XFER_ERROR_OFS)  ? {7'h00, store_err} :
    hit(rd_addr, WR_ENABLE_OFS)   ? {7'h00, wr_en_r} :
    hit(rd_addr, COPY_REQ_OFS)    ? {7'h00, copy_req_r} : map_byte;

  wire       tx_load  = instr_end ? instr_nxt[INSTR_RW] : (byte_end && rd_r);
  wire [7:0] tx_shift = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
  wire [7:0] tx_src   = tx_load ? rd_byte : tx_shift;
  wire       tx_bit   = lsb_first ? tx_src[0] : tx_src[7];
  wire       reading  = rd_r && state_r == ST_DATA && !cs_s2;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r  <= ST_INSTR;
      cnt_r    <= '0;
      instr_r  <= '0;
      rx_r     <= '0;
      tx_r     <= '0;
      addr_r   <= '0;
      left_r   <= '0;
      rd_r     <= 1'b0;
      stream_r <= 1'b0;
      sdo_bit_r <= 1'b0;
    end
    else if (cs_rise && (cnt_r[2:0] != 3'h0 || stream_r || state_r == ST_DONE))
    begin
      state_r  <= ST_INSTR;
      cnt_r    <= '0;
      rd_r     <= 1'b0;
      stream_r <= 1'b0;
    end
    else if (sclk_rise)
    begin
      unique case (state_r)
        ST_INSTR:
        begin
          instr_r <= instr_nxt;
          cnt_r   <= cnt_r + 1'b1;
          if (instr_end)
          begin
            state_r  <= ST_DATA;
            rd_r     <= instr_nxt[INSTR_RW];
            left_r   <= instr_nxt[14:13];
            stream_r <= instr_nxt[14:13] == LEN_STREAM;
            addr_r   <= instr_nxt[ADDR_W-1:0];
          end
        end
        ST_DATA:
        begin
          rx_r  <= rx_nxt;
          cnt_r <= {1'b0, cnt_r[2:0] + 1'b1};
          if (byte_end)
          begin
            addr_r <= addr_step;
            if (at_last || (!stream_r && left_r == 2'h0))
              state_r <= ST_DONE;
            else if (!stream_r)
              left_r <= left_r - 1'b1;
          end
        end
        ST_DONE:
        begin
          cnt_r <= {1'b0, cnt_r[2:0] + 1'b1};
        end
      endcase
      if (state_r != ST_DONE)
      begin
        tx_r      <= tx_src;
        sdo_bit_r <= tx_bit;
      end
    end
  end

  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_map
    always_ff @(posedge ref_clk)
    begin
      if (wr_stb && addr_r == ADDR_W'(i))
        buf_mem[i] <= rx_nxt;
      if (commit_r)
        act_mem[i] <= buf_mem[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cfg_r      <= CFG_RESET;
      commit_r   <= 1'b0;
      wr_en_r    <= 1'b0;
      copy_req_r <= 1'b0;
    end
    else
    begin
      if (wr_stb && hit(addr_r, CFG_OFS))
        cfg_r <= rx_nxt;
      commit_r <= wr_stb && hit(addr_r, COMMIT_OFS) && rx_nxt[0];
      if (wr_stb && hit(addr_r, WR_ENABLE_OFS))
        wr_en_r <= rx_nxt[0];
      if (store_done)
        copy_req_r <= 1'b0;
      else if (wr_stb && hit(addr_r, COPY_REQ_OFS))
        copy_req_r <= rx_nxt[0];
    end
  end

  // Copying starts only when the request bit is already set at commit time.
  // commit starts store
  wire store_start = commit_r && copy_req_r;

  scpns_store_engine u_store (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .start        (store_start),
    .write_enable (wr_en_r),
    .src_data     (act_mem[src_index]),
    .src_index    (src_index),
    .busy         (busy),
    .error        (store_err),
    .done         (store_done)
  );

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sdio_out_r <= 1'b0;
      sdio_oe_r  <= 1'b0;
      ro_out_r   <= 1'b0;
      ro_oe_r    <= 1'b0;
      status_r   <= 1'b0;
      nack_r     <= 1'b0;
    end
    else
    begin
      sdio_out_r <= sdo_bit_r;
      sdio_oe_r  <= reading && !unidir;
      ro_out_r   <= sdo_bit_r;
      ro_oe_r    <= reading && unidir;
      status_r   <= sel_s2 && busy;
      nack_r     <= busy;
    end
  end

  assign sdio_out            = sdio_out_r;
  assign sdio_oe             = sdio_oe_r;
  assign serial_readback_out = ro_out_r;
  assign serial_readback_oe  = ro_oe_r;
  assign status_pin          = status_r;
  assign addr_nack           = nack_r;

  property p_len_done;
    @(posedge ref_clk) disable iff (reset)
      byte_end && !stream_r && left_r == 2'h0 && !cs_rise |=> state_r == ST_DONE;
  endproperty
  a_len_done: assert property (p_len_done) else $error("transfer overran its length");

  property p_abort;
    @(posedge ref_clk) disable iff (reset)
      cs_rise && cnt_r[2:0] != 3'h0 |=> state_r == ST_INSTR && cnt_r == 4'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset port");

  property p_stream_stop;
    @(posedge ref_clk) disable iff (reset) byte_end && at_last && !cs_rise |=> state_r == ST_DONE;
  endproperty
  a_stream_stop: assert property (p_stream_stop) else $error("stream passed top");

  property p_dec_wrap;
    @(posedge ref_clk) disable iff (reset)
      byte_end && !lsb_first && addr_r == '0 && !cs_rise |=> addr_r == LAST_REG;
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

  property p_inc;
    @(posedge ref_clk) disable iff (reset)
      byte_end && lsb_first && !cs_rise |=> addr_r == $past(addr_r) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_refuse;
    @(posedge ref_clk) disable iff (reset)
      busy && !hit(rd_addr, XFER_ACTIVE_OFS) |-> rd_byte == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read served while busy");

  property p_commit_clear;
    @(posedge ref_clk) disable iff (reset) commit_r |=> !commit_r;
  endproperty
  a_commit_clear: assert property (p_commit_clear) else $error("commit stuck");

  property p_req_clear;
    @(posedge ref_clk) disable iff (reset) store_done |=> !copy_req_r ##1 !busy;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request not cleared");

  property p_ro_error;
    @(posedge ref_clk) disable iff (reset)
      wr_stb && hit(addr_r, XFER_ERROR_OFS) |=> store_err == $past(store_err);
  endproperty
  a_ro_error: assert property (p_ro_error) else $error("error bit took a write");

  c_write:  cover property (@(posedge ref_clk) disable iff (reset) wr_stb);
  c_stream: cover property (@(posedge ref_clk) disable iff (reset) byte_end && at_last);
  c_store:  cover property (@(posedge ref_clk) disable iff (reset) store_start);

endmodule // scpns_serial_port

/* verification/scpns_host_model.sv */
`timescale 1ns/1ns
module scpns_host_model
(
  input  wire logic ref_clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_in
);
  logic lsb_first;

  initial
  begin
    lsb_first = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_in = 1'b0;
  end

  task automatic half;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Callers keep the top address bits zero.
  task automatic xfer(input logic [15:0] ins, input logic [23:0] wd, input int nb,
                      output logic [23:0] rd);
    int p;
    int k;
    rd = 24'h000000;
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      p = lsb_first ? (i - 16) % 8 : 7 - (i - 16) % 8;
      k = 16 - 8 * ((i - 16) / 8) + p;
      if (i < 16)
        sdio_in = lsb_first ? ins[i] : ins[15 - i];
      else if (!ins[15])
        sdio_in = wd[k];
      else
        sdio_in = ~sdio_in;
      half;
      if (i >= 16 && ins[15])
        rd[k] = sdio_oe ? sdio_out : 1'bx;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
    half;
    cs_n = 1'b1;
    sdio_in = ~sdio_in;
    half;
    half;
  endtask
endmodule // scpns_host_model

/* verification/serial_control_port_nvm_store_bench.sv */
`timescale 1ns/1ns
module serial_control_port_nvm_store_bench;
  import scpns_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        status_pin_sel = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        host_sdio;
  logic        sdio_out;
  logic        sdio_oe;
  logic        status_pin;
  logic        addr_nack;
  logic [23:0] r;
  int          errors = 0;
  int          checks = 0;
  wire         sdio_w = sdio_oe ? sdio_out : host_sdio;
  logic        uni = 1'b0;
  logic        ro_out;
  logic        ro_oe;
  wire         rb_bit = uni ? ro_out : sdio_w;
  wire         rb_oe  = uni ? ro_oe : sdio_oe;

  always #5 ref_clk = ~ref_clk;

  scpns_serial_port dut_u (
    .ref_clk             (ref_clk),
    .reset               (reset),
    .sclk                (sclk),
    .cs_n                (cs_n),
    .sdio_in             (sdio_w),
    .status_pin_sel      (status_pin_sel),
    .sdio_out            (sdio_out),
    .sdio_oe             (sdio_oe),
    .serial_readback_out (ro_out),
    .serial_readback_oe  (ro_oe),
    .status_pin          (status_pin),
    .addr_nack           (addr_nack)
  );

  scpns_host_model host_u (
    .ref_clk  (ref_clk),
    .sdio_out (rb_bit),
    .sdio_oe  (rb_oe),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdio_in  (host_sdio)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr1(input logic [12:0] a, input logic [7:0] d);
    host_u.xfer({3'b000, a}, {d, 16'h0000}, 24, r);
  endtask

  task automatic rd1(input logic [12:0] a, input logic [7:0] e);
    host_u.xfer({3'b100, a}, 24'h000000, 24, r);
    check(r, {e, 16'h0000});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (addr_nack !== 1'b0 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 2000)
    begin
      errors++;
      report_and_stop;
    end
  endtask

  // Three byte write going down, reads of two and one byte, then a stream through the wrap.
  task automatic t_msb;
    host_u.xfer(16'h4012, 24'h5A3CC3, 40, r);
    wr1(COMMIT_OFS, 8'h01);
    host_u.xfer(16'hA011, 24'h000000, 32, r);
    check(r, 24'h3CC300);
    rd1(13'h012, 8'h5A);
    host_u.xfer(16'h6001, 24'hA51801, 40, r);
    host_u.xfer(16'hE001, 24'h000000, 40, r);
    check(r, 24'hA51800);
  endtask

  // Low bit first: addresses climb, streaming stops at the top.
  task automatic t_lsb;
    wr1(CFG_OFS, 8'h5A);
    host_u.lsb_first = 1'b1;
    host_u.xfer(16'hA010, 24'h000000, 32, r);
    check(r, 24'hC33C00);
    host_u.xfer(16'h6230, 24'h669901, 40, r);
    host_u.xfer(16'hE230, 24'h000000, 40, r);
    check(r, 24'h669900);
    wr1(CFG_OFS, 8'h18);
    host_u.lsb_first = 1'b0;
  endtask

  // A write cut off mid-byte must leave the register alone.
  task automatic t_abort;
    host_u.xfer(16'h0011, 24'hFF0000, 20, r);
    wr1(COMMIT_OFS, 8'h01);
    rd1(13'h011, 8'h3C);
  endtask

  // Readback on the separate output pin; whether the shared pin stays released is not checked.
  task automatic t_uni;
    wr1(CFG_OFS, 8'h99);
    uni = 1'b1;
    rd1(13'h011, 8'h3C);
    wr1(CFG_OFS, 8'h18);
    uni = 1'b0;
  endtask

  // Store copy with and without the write enable.
  task automatic t_store;
    wr1(WR_ENABLE_OFS, 8'h01);
    wr1(COPY_REQ_OFS, 8'h01);
    wr1(COMMIT_OFS, 8'h01);
    check({22'h0, status_pin, addr_nack}, 24'h000003);
    rd1(XFER_ACTIVE_OFS, 8'h01);
    rd1(13'h011, 8'h00);
    wait_idle;
    rd1(COPY_REQ_OFS, 8'h00);
    rd1(XFER_ACTIVE_OFS, 8'h00);
    rd1(XFER_ERROR_OFS, 8'h00);
    check({23'h0, addr_nack}, 24'h000000);
    wr1(WR_ENABLE_OFS, 8'h00);
    status_pin_sel = 1'b0;
    wr1(COPY_REQ_OFS, 8'h01);
    wr1(COMMIT_OFS, 8'h01);
    check({22'h0, status_pin, addr_nack}, 24'h000001);
    wait_idle;
    status_pin_sel = 1'b1;
    rd1(XFER_ERROR_OFS, 8'h01);
    wr1(XFER_ERROR_OFS, 8'h00);
    rd1(XFER_ERROR_OFS, 8'h01);
    rd1(13'h011, 8'h3C);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    t_msb;
    t_lsb;
    t_abort;
    t_uni;
    t_store;
    report_and_stop;
  end
endmodule // serial_control_port_nvm_store_bench
